//--- bench/async_sram_64kx16_tb.sv
/*
  Self-checking bench: random single-word accesses against a word-array model.
  Assumes the controller's hand-over timing and a shortened power-up wait.
*/
`timescale 1ns/1ns
`default_nettype none
module async_sram_64kx16_tb;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0]  req_lanes = 2'h0;
  logic        req_ready, rsp_valid, chip_select_n, write_strobe_n;
  logic        output_gate_n, low_lane_select_n, high_lane_select_n;
  logic        data_bus_oe;
  logic [15:0] rsp_rdata, word_address, data_bus_in, data_bus_out;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          seed = 74391;
  int          r, k;
  logic [15:0] mdl [0:65535];
  logic [15:0] pool [8];
  // short power wait keeps the run brief
  sramc_ctrl #(.POWER_CYCLES(4)) i_sramc_ctrl (.clk_sys, .sys_rst,
    .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes, .req_ready,
    .rsp_valid, .rsp_rdata, .chip_select_n, .write_strobe_n, .output_gate_n,
    .low_lane_select_n, .high_lane_select_n, .word_address, .data_bus_in,
    .data_bus_out, .data_bus_oe);
  sramc_mem_model i_sramc_mem_model (.clk_sys, .chip_select_n,
    .write_strobe_n, .output_gate_n, .low_lane_select_n, .high_lane_select_n,
    .word_address, .data_bus_out, .data_bus_in);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("[ERR] %0t run hung", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk_pin(logic got, logic exp, string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk_pin
  task automatic chk_word(logic [15:0] got, logic [15:0] exp, string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk_word
  // one user request, then the pin walk and the answer
  task automatic access(logic w, logic [15:0] a, logic [15:0] d,
                        logic [1:0] l);
    logic [15:0] msk;
    int n;
    msk = {{8{l[1]}}, {8{l[0]}}};
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_pin(req_ready, 1'b1, "ready never rose");
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_lanes <= l;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    if (l == 2'h0) begin
      chk_pin(chip_select_n, 1'b1, "empty lanes started access");
      return;
    end
    chk_pin(chip_select_n, 1'b0, "select not low");
    chk_pin(write_strobe_n, !w, "strobe level");
    chk_pin(output_gate_n, w, "gate level");
    chk_pin(data_bus_oe, w, "bus drive");
    chk_pin(low_lane_select_n, !l[0], "low lane select");
    chk_pin(high_lane_select_n, !l[1], "high lane select");
    chk_word(word_address, a, "address");
    if (w) begin
      chk_word(data_bus_out & msk, d & msk, "write data");
      mdl[a] = (mdl[a] & ~msk) | (d & msk);
      @(posedge clk_sys);
      #1;
      chk_pin(write_strobe_n, 1'b1, "strobe held");
    end else begin
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (rsp_valid !== 1'b1 && n < 3);
      chk_pin(rsp_valid, 1'b1, "read answer missing");
      chk_word(rsp_rdata & msk, mdl[a] & msk, "read data");
    end
  endtask : access
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_pin(req_ready, 1'b0, "ready during power wait");
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      pool[k] = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : r[15:0];
      r = $random(seed);
      access(1'b1, pool[k], r[15:0], 2'h3);
    end
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      access(1'b1, pool[1], r[15:0], k[1:0]);
      access(1'b0, pool[1], 16'h0000, 2'h3);
      access(1'b0, pool[1], 16'h0000, k[1:0]);
    end
    repeat (60) begin
      r = $random(seed);
      access(r[16], pool[r[2:0]], r[31:16], r[5:4]);
    end
    end_of_test();
  end
endmodule : async_sram_64kx16_tb
`default_nettype wire

//--- bench/sramc_mem_model.sv
/*
  Behavioural model of the 64K x 16 static memory beyond the controller.
  Assumes registered controller pins; writes land at clk_sys edges.
*/
`timescale 1ns/1ns
`default_nettype none
module sramc_mem_model (
  // clock
  input  wire logic        clk_sys,
  // memory pins
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_gate_n,
  input  wire logic        low_lane_select_n,
  input  wire logic        high_lane_select_n,
  input  wire logic [15:0] word_address,
  input  wire logic [15:0] data_bus_out,
  output logic      [15:0] data_bus_in
);
  logic [15:0] mem_reg [0:65535];
  logic [15:0] float_reg = 16'h5A5A;
  // standby whenever deselected, outputs off unless gated
  wire logic rd_on = !chip_select_n && !output_gate_n && write_strobe_n;
  wire logic wr_on = !chip_select_n && !write_strobe_n;
  always @(posedge clk_sys) begin
    // released lanes move every cycle, so a stale byte is never mistaken
    float_reg <= {float_reg[14:0], ~float_reg[15]};
    if (wr_on && !low_lane_select_n) mem_reg[word_address][7:0] <= data_bus_out[7:0];
    if (wr_on && !high_lane_select_n) mem_reg[word_address][15:8] <= data_bus_out[15:8];
  end
  // answers inside one cycle, within every access figure
  assign data_bus_in[7:0] = (rd_on && !low_lane_select_n) ?
    mem_reg[word_address][7:0] : float_reg[7:0];
  assign data_bus_in[15:8] = (rd_on && !high_lane_select_n) ?
    mem_reg[word_address][15:8] : float_reg[15:8];
endmodule : sramc_mem_model
`default_nettype wire

//--- include/sramc_pkg.sv
/*
  Package for the asynchronous static memory controller: timing figures,
  derived cycle counts, widths and state encoding.
  Assumes a 100 MHz system clock (10 ns period).
*/
package sramc_pkg;
  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_POWER_US      = 100;
  localparam int T_RC_NS         = 10;
  localparam int T_AA_NS         = 10;
  localparam int T_DOE_NS        = 5;
  localparam int T_AW_NS         = 8;
  localparam int T_SD_NS         = 5;
  localparam int T_PWE_NS        = 7;
  localparam int T_BW_NS         = 7;
  localparam int T_HZ_NS         = 6;
  // least times round up to whole cycles, never below one
  localparam int POWER_CYC  = (T_POWER_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int READ_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC  = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC   = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 14;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  // ----------------------------------------------------------------------
  // state machine, gray along power-idle-read
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER = 3'h0,
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h3,
    ST_WRITE = 3'h2,
    ST_TURN  = 3'h6
  } sramc_state_e;
endpackage : sramc_pkg

//--- rtl/sramc_ctrl.sv
/*
  Host-side controller for a 64K x 16 asynchronous static memory.
  Takes single-word read and write requests on a user port and drives the
  memory pins. Assumes a 100 MHz clock, a synchronous active-high reset and
  that read data from the memory arrives synchronous to the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sramc_ctrl #(
  parameter int POWER_CYCLES = sramc_pkg::POWER_CYC
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // user request
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [sramc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [sramc_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]                    req_lanes,
  output logic                               req_ready,
  // user answer
  output logic                               rsp_valid,
  output logic [sramc_pkg::DATA_W-1:0]       rsp_rdata,
  // memory pins
  output logic                               chip_select_n,
  output logic                               write_strobe_n,
  output logic                               output_gate_n,
  output logic                               low_lane_select_n,
  output logic                               high_lane_select_n,
  output logic [sramc_pkg::ADDR_W-1:0]       word_address,
  input  wire logic [sramc_pkg::DATA_W-1:0]  data_bus_in,
  output logic [sramc_pkg::DATA_W-1:0]       data_bus_out,
  output logic                               data_bus_oe
);
  // ----------------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------------
  sramc_pkg::sramc_state_e state_reg, state_next;
  logic [sramc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic                        cnt_done;
  logic                        take_req;
  logic                        lanes_any;

  assign cnt_done  = (cnt_reg == sramc_pkg::CNT_ZERO);
  assign lanes_any = |req_lanes;
  assign take_req  = req_ready & req_valid & lanes_any;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 14'h0001;
    unique case (state_reg)
      sramc_pkg::ST_POWER: begin
        if (cnt_done) begin
          state_next = sramc_pkg::ST_IDLE;
        end
      end
      sramc_pkg::ST_IDLE: begin
        if (take_req && req_write) begin
          state_next = sramc_pkg::ST_WRITE;
          cnt_next   = sramc_pkg::CNT_W'(sramc_pkg::WRITE_CYC - 1);
        end else if (take_req) begin
          state_next = sramc_pkg::ST_READ;
          cnt_next   = sramc_pkg::CNT_W'(sramc_pkg::READ_CYC);
        end
      end
      sramc_pkg::ST_READ: begin
        if (cnt_done) begin
          state_next = sramc_pkg::ST_TURN;
          cnt_next   = sramc_pkg::CNT_W'(sramc_pkg::TURN_CYC - 1);
        end
      end
      sramc_pkg::ST_WRITE: begin
        if (cnt_done) begin
          state_next = sramc_pkg::ST_IDLE;
        end
      end
      sramc_pkg::ST_TURN: begin
        if (cnt_done) begin
          state_next = sramc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sramc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= sramc_pkg::ST_POWER;
      cnt_reg   <= sramc_pkg::CNT_W'(POWER_CYCLES - 1);
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive, all from flops
  // ----------------------------------------------------------------------
  logic in_read_next, in_write_next, idle_next;
  assign idle_next     = (state_next == sramc_pkg::ST_IDLE);
  assign in_read_next  = (state_next == sramc_pkg::ST_READ);
  assign in_write_next = (state_next == sramc_pkg::ST_WRITE);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chip_select_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      output_gate_n  <= 1'b1;
      data_bus_oe    <= 1'b0;
      req_ready      <= 1'b0;
    end else begin
      // select dropped between accesses so the memory idles in standby
      chip_select_n  <= ~(in_read_next | in_write_next);
      // strobe held high for all of a read; window ends on all edges at once
      write_strobe_n <= ~in_write_next;
      // gate opens only on reads, after our driver has been released
      output_gate_n  <= ~in_read_next;
      data_bus_oe    <= in_write_next;
      req_ready      <= idle_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      low_lane_select_n  <= 1'b1;
      high_lane_select_n <= 1'b1;
      word_address       <= 16'h0000;
      data_bus_out       <= 16'h0000;
    end else if (take_req) begin
      // address, data and lanes launch with the controls: setup to write
      // end is then the whole pulse, and no hold is needed after it
      low_lane_select_n  <= ~req_lanes[0];
      high_lane_select_n <= ~req_lanes[1];
      word_address       <= req_addr;
      data_bus_out       <= req_wdata;
    end else if (state_next == sramc_pkg::ST_IDLE) begin
      low_lane_select_n  <= 1'b1;
      high_lane_select_n <= 1'b1;
    end
  end

  // read data captured one cycle after access time elapsed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == sramc_pkg::ST_READ && cnt_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_bus_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_NO_ACCESS_IN_POWERUP: assert property (@(posedge clk_sys)
    disable iff (sys_rst) (state_reg == sramc_pkg::ST_POWER) |-> chip_select_n)
    else $error("memory selected during power-up wait");
  AST_READ_STROBE_HIGH: assert property (@(posedge clk_sys)
    disable iff (sys_rst) !output_gate_n |-> write_strobe_n)
    else $error("strobe low while gate open");
  AST_NO_CONTENTION: assert property (@(posedge clk_sys)
    disable iff (sys_rst) !(data_bus_oe && !output_gate_n))
    else $error("bus driven while memory outputs enabled");
  AST_WRITE_WIDTH: assert property (@(posedge clk_sys)
    disable iff (sys_rst) $rose(write_strobe_n) |->
      $past(!low_lane_select_n || !high_lane_select_n))
    else $error("lane released before write end");
  AST_WRITE_WINDOW: assert property (@(posedge clk_sys)
    disable iff (sys_rst) !write_strobe_n |->
      !chip_select_n && !(low_lane_select_n && high_lane_select_n))
    else $error("strobe low without select and lane");
  AST_READ_TIME: assert property (@(posedge clk_sys)
    disable iff (sys_rst) $fell(output_gate_n) |-> ##2 rsp_valid)
    else $error("read answer not at access time");
  AST_DATA_STABLE: assert property (@(posedge clk_sys)
    disable iff (sys_rst) $rose(write_strobe_n) |-> $stable(data_bus_out)
      && $stable(word_address))
    else $error("address or data moved inside write");
  AST_STANDBY_IDLE: assert property (@(posedge clk_sys)
    disable iff (sys_rst) req_ready |-> chip_select_n)
    else $error("memory selected while idle");
  AST_TURN_GAP: assert property (@(posedge clk_sys)
    disable iff (sys_rst) $rose(output_gate_n) |-> !data_bus_oe)
    else $error("bus driven right after read");
  COV_READ: cover property (@(posedge clk_sys) rsp_valid);
  COV_WRITE: cover property (@(posedge clk_sys) $fell(write_strobe_n));
  COV_BYTE_WRITE: cover property (@(posedge clk_sys)
    !write_strobe_n && high_lane_select_n);
endmodule : sramc_ctrl
`default_nettype wire
